// [design/rsc_delay.sv]
// Qualification counter: pulses once after a condition has held past a cycle count.
`timescale 1ns/1ps
module rsc_delay
  import rsc_pkg::*;
#(
  parameter int          CNT_W = 16,
  parameter logic [15:0] LIMIT = 16'h0001
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Condition and result
  input  wire logic cond,
  output logic      fire
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             done;

  // The count saturates at the limit so one episode gives only one pulse.
  assign done     = (cnt_reg == LIMIT[CNT_W-1:0]);
  assign cnt_next = !cond ? '0 : (done ? cnt_reg : cnt_reg + 1'b1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign fire = cond && (cnt_reg == LIMIT[CNT_W-1:0] - 1'b1);

endmodule

// [design/rsc_pkg.sv]
// Package with register map, codes and timing constants of the reset source controller.
package rsc_pkg;

  // Register word byte addresses on the Avalon-MM slave.
  localparam logic [3:0] ADDR_THRESH   = 4'h0;
  localparam logic [3:0] ADDR_FLAGS    = 4'h4;
  localparam logic [3:0] ADDR_GUARD    = 4'h8;
  localparam logic [3:0] ADDR_WDT_KEY  = 4'hc;
  localparam logic [3:0] ADDR_FLASH2   = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic       PAGE_REGS     = 1'h0;
  localparam logic       PAGE_CTRL     = 1'h1;

  // Threshold select codes.
  localparam logic [7:0] THR_1V7       = 8'h66;
  localparam logic [7:0] THR_1V9       = 8'h55;
  localparam logic [7:0] THR_2V55      = 8'h33;
  localparam logic [7:0] THR_3V15      = 8'h99;
  localparam logic [7:0] THR_3V8       = 8'haa;
  localparam logic [7:0] THR_DISABLE   = 8'hf0;
  localparam logic [7:0] THR_RESET     = THR_1V7;

  // Reset guard and watchdog key codes.
  localparam logic [7:0] GUARD_OK_A    = 8'h55;
  localparam logic [7:0] GUARD_OK_B    = 8'haa;
  localparam logic [7:0] GUARD_RESET   = GUARD_OK_A;
  localparam logic [4:0] KEY_ENABLE    = 5'h0a;
  localparam logic [4:0] KEY_DISABLE   = 5'h15;
  localparam logic [4:0] KEY_RESET     = KEY_ENABLE;

  // Flash programming reset command.
  localparam logic [7:0] FLASH_RST_CMD = 8'h55;

  // Cause flag bit positions.
  localparam int FLAG_KEY   = 0;
  localparam int FLAG_THR   = 1;
  localparam int FLAG_UV    = 2;
  localparam int FLAG_GUARD = 3;
  localparam int FLAG_W     = 4;

  // Status bit positions (timeout, power down, monitor active, low mode).
  localparam int STAT_TO  = 0;
  localparam int STAT_PDF = 1;
  localparam int STAT_MON = 2;
  localparam int STAT_LP  = 3;

  // Timing, in nanoseconds, and the clock period.
  localparam int CLK_PERIOD_NS      = 8;
  localparam int UV_FILTER_NS       = 120000;
  localparam int CORRUPT_DELAY_NS   = 50000;
  localparam int RESET_PULSE_NS     = 64;
  localparam int UV_FILTER_CYC      = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CORRUPT_DELAY_CYC  = (CORRUPT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC    = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W              = 16;

  // Reset sequencer states.
  typedef enum logic [2:0]
  {
    SEQ_IDLE  = 3'b001,
    SEQ_HOLD  = 3'b010,
    SEQ_LOCAL = 3'b100
  } rsc_seq_t;

endpackage

// [design/rsc_top.sv]
// Reset source controller: undervoltage filter, corrupt-value resets, cause flags, Avalon slave.
//
// How it works
// - Monitor runs when enabled, forced off in sleep or idle.
// - Low supply must persist past filter time before an undervoltage reset.
// - Five threshold codes are valid, code f0 disables the monitor.
// - Any other threshold code resets after delay, flags, restores default code.
// - A qualified undervoltage reset keeps the threshold register contents.
// - Undervoltage flag, bit 2, set by that reset, cleared by writing zero.
// - Threshold-corrupt flag, bit 1, set on bad code, cleared by writing zero.
// - Flag bits 7 to 4 read zero; power-on clears bits 3 to 0.
// - Writing 55 to the second flash control register resets the device.
// - Watchdog timeout in run mode gives full reset and sets timeout flag.
// - Watchdog timeout in low power clears only counter and stack pointer.
// - Timeout, power-down zero at power-on, kept by undervoltage reset.
// - Power-on reset starts the core in its defined initial state.
// - Guard register bad value sets bit 3, delayed reset, software clears.
// - Watchdog key bad value sets bit 0, delayed reset, software clears.
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Supply and core status
  input  wire logic        low_supply_in,
  input  wire logic        low_power_mode,
  input  wire logic        watchdog_timeout,
  // Reset outputs
  output logic             sys_reset_n,
  output logic             pc_sp_clear,
  output logic             undervoltage_active
);

  // ***********************************************
  // Input synchronisers
  // ***********************************************
  // Low supply comes from the analog comparator, so it is retimed before any count.
  logic low_meta_reg;
  logic low_sync_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_meta_reg <= 1'b0;
      low_sync_reg <= 1'b0;
    end
    else
    begin
      low_meta_reg <= low_supply_in;
      low_sync_reg <= low_meta_reg;
    end
  end

  // ***********************************************
  // Registers
  // ***********************************************
  // Cause flags sit in bits 3 to 0; bits 7 to 4 are not stored and read zero.
  logic [7:0] threshold_select_reg;
  logic [7:0] guard_reg;
  logic [4:0] watchdog_enable_key_reg;
  logic [3:0] flags_reg;
  logic       watchdog_timeout_flag_reg;
  logic       power_down_flag_reg;
  rsc_seq_t   seq_reg;
  logic [CNT_W-1:0] pulse_cnt_reg;

  // ***********************************************
  // Code decoding
  // ***********************************************
  logic thr_valid;
  logic thr_disabled;
  logic guard_valid;
  logic key_valid;
  logic in_reset;

  // Each register accepts only its listed codes; anything else arms a delayed reset.
  assign thr_valid    = (threshold_select_reg == THR_1V7) || (threshold_select_reg == THR_1V9)
                     || (threshold_select_reg == THR_2V55) || (threshold_select_reg == THR_3V15)
                     || (threshold_select_reg == THR_3V8)
                     || (threshold_select_reg == THR_DISABLE);
  assign thr_disabled = (threshold_select_reg == THR_DISABLE);
  assign guard_valid  = (guard_reg == GUARD_OK_A) || (guard_reg == GUARD_OK_B);
  assign key_valid    = (watchdog_enable_key_reg == KEY_ENABLE)
                     || (watchdog_enable_key_reg == KEY_DISABLE);
  assign in_reset     = (seq_reg == SEQ_HOLD);

  // ***********************************************
  // Qualification timers
  // ***********************************************
  logic mon_on;
  logic uv_fire;
  logic thr_fire;
  logic guard_fire;
  logic key_fire;

  // The monitor is off in sleep or idle even with a valid code.
  assign mon_on = thr_valid && !thr_disabled && !low_power_mode;

  // The undervoltage limit is one above the filter count, so a reset needs a
  // low episode longer than the filter time; shorter ones leave no trace.
  rsc_delay #(.CNT_W(CNT_W), .LIMIT(16'(UV_FILTER_CYC + 1))) u_uv_filter
  (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (mon_on && low_sync_reg && !in_reset),
    .fire  (uv_fire)
  );

  rsc_delay #(.CNT_W(CNT_W), .LIMIT(16'(CORRUPT_DELAY_CYC))) u_thr_delay
  (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (!thr_valid && !in_reset),
    .fire  (thr_fire)
  );

  rsc_delay #(.CNT_W(CNT_W), .LIMIT(16'(CORRUPT_DELAY_CYC))) u_guard_delay
  (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (!guard_valid && !in_reset),
    .fire  (guard_fire)
  );

  rsc_delay #(.CNT_W(CNT_W), .LIMIT(16'(CORRUPT_DELAY_CYC))) u_key_delay
  (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (!key_valid && !in_reset),
    .fire  (key_fire)
  );

  // ***********************************************
  // Bus decode
  // ***********************************************
  logic       page;
  logic [3:0] word_addr;
  logic       acc;
  logic       wr;
  logic       wr_thresh;
  logic       wr_flags;
  logic       wr_guard;
  logic       wr_key;
  logic       wr_flash2;
  logic       mapped;
  logic [7:0] wbyte;
  logic       flash_rst;
  logic       wd_run;
  logic       wd_low;
  logic       full_req;
  logic       other_req;

  // A write acts at the edge where waitrequest is seen low; lane 0 carries the data.
  // Writes during the reset hold are dropped so a cause cannot be armed again.
  assign page      = avs_address[4];
  assign word_addr = {avs_address[1:0], 2'b00};
  assign acc       = (avs_read || avs_write) && avs_waitrequest == 1'b0;
  assign wr        = avs_write && !avs_waitrequest && avs_byteenable[0] && !in_reset;
  assign wbyte     = avs_writedata[7:0];
  assign mapped    = !avs_address[3] && !avs_address[2]
                  && ((page == PAGE_REGS) || (word_addr == ADDR_FLASH2)
                  || (word_addr == ADDR_STATUS));
  assign wr_thresh = wr && mapped && page == PAGE_REGS && word_addr == ADDR_THRESH;
  assign wr_flags  = wr && mapped && page == PAGE_REGS && word_addr == ADDR_FLAGS;
  assign wr_guard  = wr && mapped && page == PAGE_REGS && word_addr == ADDR_GUARD;
  assign wr_key    = wr && mapped && page == PAGE_REGS && word_addr == ADDR_WDT_KEY;
  assign wr_flash2 = wr && mapped && page == PAGE_CTRL && word_addr == ADDR_FLASH2;
  assign flash_rst = wr_flash2 && (wbyte == FLASH_RST_CMD);
  assign wd_run    = watchdog_timeout && !low_power_mode && !in_reset;
  assign wd_low    = watchdog_timeout && low_power_mode && !in_reset;
  assign full_req  = uv_fire || thr_fire || guard_fire || key_fire
                  || flash_rst || wd_run;

  // Every cause but a qualified undervoltage also restores the threshold code.
  assign other_req = thr_fire || guard_fire || key_fire || flash_rst || wd_run;

  // ***********************************************
  // Cause flags: hardware set wins over software clear
  // ***********************************************
  logic [3:0] flag_set;
  logic [3:0] flags_next;

  assign flag_set = {guard_fire, uv_fire, thr_fire, key_fire};

  // Software writes a zero to clear a flag and a one to keep it.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flag
      assign flags_next[gi] = flag_set[gi] ? 1'b1
                            : ((wr_flags && !wbyte[gi]) ? 1'b0 : flags_reg[gi]);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= 4'h0;
    else
      flags_reg <= flags_next;
  end

  // ***********************************************
  // Control registers
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      threshold_select_reg <= THR_RESET;
    else if (thr_fire)
      threshold_select_reg <= THR_RESET;
    else if (other_req)
      threshold_select_reg <= THR_RESET;
    else if (wr_thresh)
      threshold_select_reg <= wbyte;
  end

  // Guard and key codes return to their safe values on every full reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      guard_reg <= GUARD_RESET;
    else if (full_req)
      guard_reg <= GUARD_RESET;
    else if (wr_guard)
      guard_reg <= wbyte;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      watchdog_enable_key_reg <= KEY_RESET;
    else if (full_req)
      watchdog_enable_key_reg <= KEY_RESET;
    else if (wr_key)
      watchdog_enable_key_reg <= wbyte[4:0];
  end

  // Timeout and power-down status, kept over an undervoltage reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watchdog_timeout_flag_reg <= 1'b0;
      power_down_flag_reg       <= 1'b0;
    end
    else if (wd_low)
    begin
      watchdog_timeout_flag_reg <= 1'b1;
      power_down_flag_reg       <= 1'b1;
    end
    else if (wd_run)
      watchdog_timeout_flag_reg <= 1'b1;
  end

  // ***********************************************
  // Reset sequencer
  // ***********************************************
  logic             pulse_done;
  rsc_seq_t         seq_next;

  // The hold counts from zero in its first cycle, so sys_reset_n stays low
  // for exactly the pulse length.
  assign pulse_done = (pulse_cnt_reg == CNT_W'(RESET_PULSE_CYC - 1));

  // A full request that meets the clear cycle still starts the hold.
  always_comb
  begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE:  seq_next = full_req ? SEQ_HOLD : (wd_low ? SEQ_LOCAL : SEQ_IDLE);
      SEQ_HOLD:  seq_next = pulse_done ? SEQ_IDLE : SEQ_HOLD;
      SEQ_LOCAL: seq_next = full_req ? SEQ_HOLD : SEQ_IDLE;
      default:   seq_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_reg       <= SEQ_HOLD;
      pulse_cnt_reg <= '0;
    end
    else
    begin
      seq_reg       <= seq_next;
      pulse_cnt_reg <= (seq_next == SEQ_HOLD && seq_reg == SEQ_HOLD) ? pulse_cnt_reg + 1'b1 : '0;
    end
  end

  // ***********************************************
  // Outputs and read data
  // ***********************************************
  logic [31:0] rdata;

  // Unmapped words and the write-only flash control word read as zero.
  assign rdata = !mapped ? 32'h0
               : (page == PAGE_CTRL && word_addr == ADDR_STATUS)
                 ? {28'h0, low_power_mode, mon_on, power_down_flag_reg, watchdog_timeout_flag_reg}
               : (page == PAGE_CTRL) ? 32'h0
               : (word_addr == ADDR_THRESH) ? {24'h0, threshold_select_reg}
               : (word_addr == ADDR_FLAGS) ? {28'h0, flags_reg}
               : (word_addr == ADDR_GUARD) ? {24'h0, guard_reg}
               : {27'h0, watchdog_enable_key_reg};

  // Waitrequest drops for one cycle per access, and read data is captured as the
  // request is first seen, so it stands in the cycle that completes the access.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest     <= 1'b1;
      avs_readdata        <= 32'h0;
      avs_response        <= 2'h0;
      sys_reset_n         <= 1'b0;
      pc_sp_clear         <= 1'b0;
      undervoltage_active <= 1'b0;
    end
    else
    begin
      avs_waitrequest     <= !((avs_read || avs_write) && avs_waitrequest);
      avs_readdata        <= (avs_read && avs_waitrequest) ? rdata : avs_readdata;
      avs_response        <= (!mapped && acc) ? 2'h2 : 2'h0;
      sys_reset_n         <= (seq_next != SEQ_HOLD);
      pc_sp_clear         <= (seq_next == SEQ_LOCAL);
      undervoltage_active <= mon_on;
    end
  end

endmodule

// [dv/rsc_asserts.sv]
// Port-level concurrent checks for the reset source controller.
`timescale 1ns/1ps
module rsc_asserts
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Status and reset outputs
  input wire logic low_power_mode,
  input wire logic watchdog_timeout,
  input wire logic sys_reset_n,
  input wire logic pc_sp_clear,
  input wire logic undervoltage_active
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_req;
    $rose(avs_read || avs_write) && avs_waitrequest && sys_reset_n;
  endsequence
  sequence s_hold;
    !sys_reset_n [*8];
  endsequence
  sequence s_sleep_to;
    watchdog_timeout && low_power_mode && sys_reset_n;
  endsequence

  a_bus_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_bus_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("answer without a request");
  a_reset_hold: assert property ($fell(sys_reset_n) |-> s_hold)
    else $error("system reset shorter than eight cycles");
  a_wdt_run: assert property (watchdog_timeout && !low_power_mode && sys_reset_n |-> ##[1:2] !sys_reset_n)
    else $error("run mode timeout gave no reset");
  a_wdt_sleep: assert property (s_sleep_to |-> ##[1:2] pc_sp_clear)
    else $error("sleep timeout gave no counter clear");
  a_sleep_keep: assert property (s_sleep_to |=> sys_reset_n [*3])
    else $error("sleep timeout reset the system");
  a_clear_pulse: assert property (pc_sp_clear |=> !pc_sp_clear)
    else $error("counter clear longer than one cycle");
  a_mon_sleep: assert property (low_power_mode [*2] |-> !undervoltage_active)
    else $error("monitor active in low power mode");
endmodule

// [dv/rsc_top_tb.sv]
// Self-checking bench for the reset source controller.
`timescale 1ns/1ps
module rsc_top_tb;
  import rsc_pkg::*;
  localparam logic [7:0] CODES [6] = '{THR_1V7, THR_1V9, THR_2V55, THR_3V15, THR_3V8, THR_DISABLE};
  localparam logic [4:0] A_THR = {PAGE_REGS, 2'b00, ADDR_THRESH[3:2]};
  localparam logic [4:0] A_FLG = {PAGE_REGS, 2'b00, ADDR_FLAGS[3:2]};
  localparam logic [4:0] A_GRD = {PAGE_REGS, 2'b00, ADDR_GUARD[3:2]};
  localparam logic [4:0] A_KEY = {PAGE_REGS, 2'b00, ADDR_WDT_KEY[3:2]};
  localparam logic [4:0] A_FL2 = {PAGE_CTRL, 2'b00, ADDR_FLASH2[3:2]};
  localparam logic [4:0] A_STA = {PAGE_CTRL, 2'b00, ADDR_STATUS[3:2]};
  localparam logic [4:0] A_BAD = {PAGE_CTRL, 2'b00, 2'b10};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        low_supply_in = 1'b0;
  logic        low_power_mode = 1'b0;
  logic        watchdog_timeout = 1'b0;
  logic        sys_reset_n;
  logic        pc_sp_clear;
  logic        undervoltage_active;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n_resets = 0;
  int          cnt;
  int          base;
  logic [31:0] rd_val;

  rsc_top u_rsc_top (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .low_supply_in,
    .low_power_mode, .watchdog_timeout, .sys_reset_n, .pc_sp_clear, .undervoltage_active);

  always #4 clk = ~clk;
  always @(negedge sys_reset_n) n_resets++;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    n_errors++;
    $display("BAD %s expected done seen timeout", what);
    print_verdict();
  endtask

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic access(input logic wr, input logic [4:0] adr, input logic [7:0] dat);
    int i;
    @(posedge clk);
    avs_address <= adr;
    avs_writedata <= {24'h0, dat};
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50 && avs_waitrequest !== 1'b0; i++)
      @(negedge clk);
    if (i == 50)
      hang("bus");
    @(posedge clk);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [4:0] adr, input logic [31:0] exp);
    access(1'b0, adr, 8'h00);
    check(what, rd_val, exp);
  endtask

  task automatic wait_rst(input logic val, input int bound);
    cnt = 0;
    while (sys_reset_n !== val)
    begin
      @(negedge clk);
      cnt++;
      if (cnt > bound)
        hang("reset");
    end
  endtask

  // Writes a bad code, checks the delayed reset, the flag and the restored value.
  task automatic corrupt(input logic [4:0] adr, input logic [7:0] bad, input logic [31:0] flg,
                         input logic [7:0] def);
    access(1'b1, adr, bad);
    wait_rst(1'b0, CORRUPT_DELAY_CYC + 20);
    check("delay", 32'(cnt >= CORRUPT_DELAY_CYC - 4), 32'h1);
    wait_rst(1'b1, 50);
    rd("flags", A_FLG, flg);
    rd("restored", adr, {24'h0, def});
    $display("test corrupt code %h done", bad);
  endtask

  task automatic wdt_pulse(input logic lp);
    @(posedge clk);
    low_power_mode <= lp;
    @(posedge clk);
    watchdog_timeout <= 1'b1;
    @(posedge clk);
    watchdog_timeout <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_rst(1'b1, 100);
    rd("thr", A_THR, {24'h0, THR_RESET});
    rd("flags", A_FLG, 32'h0);
    rd("guard", A_GRD, {24'h0, GUARD_RESET});
    rd("key", A_KEY, {27'h0, KEY_RESET});
    rd("status", A_STA, 32'h4);
    @(negedge clk);
    check("resp ok", {30'h0, avs_response}, 32'h0);
    rd("unmapped", A_BAD, 32'h0);
    @(negedge clk);
    check("resp bad", {30'h0, avs_response}, 32'h2);
    access(1'b1, A_FLG, 8'hff);
    rd("flags", A_FLG, 32'h0);
    avs_byteenable <= 4'he;
    access(1'b1, A_THR, THR_1V9);
    avs_byteenable <= 4'hf;
    rd("lane off", A_THR, {24'h0, THR_RESET});
    $display("test reset values done");
    foreach (CODES[i])
    begin
      access(1'b1, A_THR, CODES[i]);
      rd("code", A_THR, {24'h0, CODES[i]});
      check("mon", {31'h0, undervoltage_active}, 32'(CODES[i] != THR_DISABLE));
    end
    $display("test threshold codes done");
    corrupt(A_THR, 8'h12, 32'h2, THR_RESET);
    access(1'b1, A_FLG, 8'h00);
    rd("flags", A_FLG, 32'h0);
    corrupt(A_GRD, 8'h00, 32'h8, GUARD_RESET);
    corrupt(A_KEY, 8'h1f, 32'h9, {3'h0, KEY_RESET});
    access(1'b1, A_FLG, 8'h00);
    rd("flags", A_FLG, 32'h0);
    access(1'b1, A_THR, THR_3V8);
    base = n_resets;
    low_supply_in <= 1'b1;
    repeat (10000) @(posedge clk);
    low_supply_in <= 1'b0;
    low_power_mode <= 1'b1;
    @(posedge clk);
    low_supply_in <= 1'b1;
    repeat (UV_FILTER_CYC + 1000) @(posedge clk);
    low_supply_in <= 1'b0;
    low_power_mode <= 1'b0;
    repeat (5) @(posedge clk);
    check("short low", n_resets - base, 32'h0);
    low_supply_in <= 1'b1;
    wait_rst(1'b0, UV_FILTER_CYC + 50);
    check("filter", 32'(cnt >= UV_FILTER_CYC), 32'h1);
    @(posedge clk);
    low_supply_in <= 1'b0;
    wait_rst(1'b1, 50);
    rd("uv flag", A_FLG, 32'h4);
    rd("thr kept", A_THR, {24'h0, THR_3V8});
    rd("status", A_STA, 32'h4);
    access(1'b1, A_FLG, 8'h00);
    rd("flags", A_FLG, 32'h0);
    $display("test undervoltage done");
    base = n_resets;
    wdt_pulse(1'b1);
    cnt = 0;
    repeat (4)
    begin
      @(negedge clk);
      if (pc_sp_clear === 1'b1)
        cnt++;
    end
    check("clear", cnt, 32'h1);
    rd("status", A_STA, 32'hb);
    check("no reset", n_resets - base, 32'h0);
    wdt_pulse(1'b0);
    wait_rst(1'b0, 10);
    wait_rst(1'b1, 50);
    rd("status", A_STA, 32'h7);
    rd("thr", A_THR, {24'h0, THR_RESET});
    $display("test watchdog done");
    base = n_resets;
    access(1'b1, A_FL2, 8'h54);
    repeat (20) @(posedge clk);
    check("no reset", n_resets - base, 32'h0);
    access(1'b1, A_FL2, FLASH_RST_CMD);
    wait_rst(1'b0, 10);
    wait_rst(1'b1, 50);
    check("resets", n_resets - base, 32'h1);
    $display("test flash reset done");
    access(1'b1, A_THR, THR_1V9);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_rst(1'b1, 100);
    rd("por thr", A_THR, {24'h0, THR_RESET});
    rd("por status", A_STA, 32'h4);
    rd("por flags", A_FLG, 32'h0);
    $display("test power-on again done");
    print_verdict();
  end
endmodule

bind rsc_top rsc_asserts u_rsc_asserts (.clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .low_power_mode, .watchdog_timeout, .sys_reset_n, .pc_sp_clear, .undervoltage_active);
